// *** core/sadc_consts.svh ***
// register offsets, field positions, reset values and conversion lengths
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH
// register indices, byte address is four times the index
`define SADC_IDX_CTRL1 8'h0E
`define SADC_IDX_CTRL2 8'h0F
`define SADC_IDX_STAT 8'h20
`define SADC_IDX_RESH 8'h21
// first control register fields
`define SADC_START_BIT 7
`define SADC_MODE_MSB 6
`define SADC_MODE_LSB 5
`define SADC_GATE_BIT 4
`define SADC_CHAN_MSB 3
`define SADC_CHAN_LSB 0
// second control register fields
`define SADC_LADDER_BIT 5
`define SADC_ACK_MSB 3
`define SADC_ACK_LSB 1
// status register fields
`define SADC_DONE_BIT 5
`define SADC_BUSY_BIT 4
// reset values
`define SADC_CTRL1_RST 8'h10
`define SADC_CTRL2_RST 8'h00
`define SADC_RES_RST 10'h000
// conversion lengths in high_freq_osc_clock cycles (pclk)
`define SADC_CYC_ACK0 11'h027
`define SADC_CYC_ACK2 11'h04E
`define SADC_CYC_ACK3 11'h09C
`define SADC_CYC_ACK4 11'h138
`define SADC_CYC_ACK5 11'h270
`define SADC_CYC_ACK6 11'h4E0
`endif

// *** core/sadc_pkg.sv ***
// types shared by the converter sequencer files
package sadc_pkg;
   typedef enum logic [2:0] {
      SADC_IDLE = 3'b001,
      SADC_LOAD = 3'b010,
      SADC_CONV = 3'b100
   } sadc_state_t;
   typedef enum logic [1:0] {
      SADC_MODE_OFF = 2'b00,
      SADC_MODE_SINGLE = 2'b01,
      SADC_MODE_RSVD = 2'b10,
      SADC_MODE_REPEAT = 2'b11
   } sadc_mode_t;
endpackage

// *** core/sadc_if.sv ***
// interfaces between the sequencer and its timer and bus slave
`timescale 1ns/10ps
interface sadc_tmr_if;
   logic load;
   logic clear;
   logic [10:0] len;
   logic expire;
   modport ctl (output load, output clear, output len, input expire);
   modport tmr (input load, input clear, input len, output expire);
endinterface

interface sadc_bus_if;
   logic wr_stb;
   logic rd_stb;
   logic [7:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic hit;
   modport slv (output wr_stb, output rd_stb, output idx, output wdata, input rdata, input hit);
   modport regs (input wr_stb, input rd_stb, input idx, input wdata, output rdata, output hit);
endinterface

// *** core/sadc_tmr.sv ***
// conversion length timer: counts cycles from load up to the selected length
`timescale 1ns/10ps
module sadc_tmr (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclken,
   sadc_tmr_if.tmr t
);
   logic [10:0] cnt_reg;
   logic run_reg;

   assign t.expire = run_reg && (cnt_reg == t.len);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 11'h000;
         run_reg <= 1'b0;
      end else if (pclken) begin
         if (t.clear) begin
            cnt_reg <= 11'h000;
            run_reg <= 1'b0;
         end else if (t.load) begin
            cnt_reg <= 11'h001;
            run_reg <= 1'b1;
         end else if (t.expire) begin
            run_reg <= 1'b0;
         end else if (run_reg) begin
            cnt_reg <= cnt_reg + 11'h001;
         end
      end
   end
endmodule

// *** core/sadc_apb.sv ***
// apb slave front end: one wait state, registered read data and error
`timescale 1ns/10ps
module sadc_apb (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclken,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   sadc_bus_if.slv bus
);
   logic ok;
   logic acc;

   assign bus.idx = paddr[9:2];
   assign bus.wdata = pwdata[7:0];
   assign ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) && bus.hit;
   assign acc = psel && penable;
   assign bus.wr_stb = acc && pready && pwrite && ok;
   assign bus.rd_stb = acc && pready && !pwrite && ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (pclken) begin
         pready <= acc && !pready;
         if (acc && !pready) begin
            pslverr <= !ok;
            prdata <= (!pwrite && ok) ? {24'h000000, bus.rdata} : 32'h0000_0000;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end
endmodule

// *** core/sadc_top.sv ***
// 10-bit successive-approximation converter sequencer with apb registers
// Function
// R01: conversion time code selects 39 to 1248 cycles; 001 and 111 inhibited
// R02: upper result register holds result bits 9..2, msb in bit 7
// R03: status register holds result bits 1..0 in 7..6, done 5, busy 4
// R04: done flag reads 0 before and during conversion, 1 once stored; in repeat mode it stays 1 during the next conversion
// R05: busy set at conversion start, cleared at end and in standby
// R06: reading the upper result register clears the done flag
// R07: software reads status register before upper result register
// R08: status bits 3..0 are unspecified; here they read zero
// R09: single mode start bit begins one conversion of selected channel
// R10: completion stores result, sets done and pulses interrupt together
// R11: start bit clears itself once its conversion has started
// R12: software must not restart while a conversion is running
// R13: repeat mode start begins conversions, each completion starts the next
// R14: writing mode 00 stops at once and discards the partial result
// R15: new start before read clears done but keeps old result
// R16: software programs both control registers before setting start
// R17: standby aborts, resets both control registers, loses results
// R18: after standby the converter stays idle until a new start
// R19: standby disconnects the reference ladder
// R20: software avoids port activity during conversion
// R21: mode field decodes off, single, reserved, repeat
// R22: channel field selects inputs 0 to 5, other codes reserved
// R23: ladder bit 0 connects only during conversion, 1 always
// R24: count cycles from start to length, then latch the datapath value
// R25: start bit ignored while mode selects disabled, no flag change
`timescale 1ns/10ps
`include "sadc_consts.svh"
module sadc_top
   import sadc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclken,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic standby_req,
   input wire logic [9:0] sar_value,
   output logic sar_start,
   output logic [3:0] channel_select_field,
   output logic analog_input_gate,
   output logic ladder_connect_bit,
   output logic conv_done_irq
);
   sadc_tmr_if tif ();
   sadc_bus_if bif ();

   logic [7:0] ctrl1_reg;
   logic [5:0] ctrl2_reg;
   logic conv_start_bit_reg;
   logic conv_done_flag_reg;
   logic conv_busy_flag_reg;
   logic [9:0] result_reg;
   logic [10:0] len_reg;
   logic [10:0] len_next;
   logic ladder_reg;
   logic irq_reg;
   logic sar_start_reg;
   sadc_state_t state_reg;
   sadc_state_t state_next;
   sadc_mode_t mode_cur;
   sadc_mode_t mode_wr;
   logic [2:0] ack_cur;
   logic wr_ctrl1;
   logic wr_ctrl2;
   logic rd_resh;
   logic wr_run_mode;
   logic ack_ok;
   logic abort;
   logic store;
   logic sw_start;

   sadc_apb u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .pclken(pclken),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .bus(bif.slv)
   );

   sadc_tmr u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .pclken(pclken),
      .t(tif.tmr)
   );

   assign mode_cur = sadc_mode_t'(ctrl1_reg[`SADC_MODE_MSB:`SADC_MODE_LSB]);
   assign mode_wr = sadc_mode_t'(bif.wdata[`SADC_MODE_MSB:`SADC_MODE_LSB]);
   assign ack_cur = ctrl2_reg[`SADC_ACK_MSB:`SADC_ACK_LSB];
   assign wr_ctrl1 = bif.wr_stb && (bif.idx == `SADC_IDX_CTRL1) && !standby_req;
   assign wr_ctrl2 = bif.wr_stb && (bif.idx == `SADC_IDX_CTRL2) && !standby_req;
   assign rd_resh = bif.rd_stb && (bif.idx == `SADC_IDX_RESH);
   // R21 mode decode: only single and repeat run the converter
   assign wr_run_mode = (mode_wr == SADC_MODE_SINGLE) || (mode_wr == SADC_MODE_REPEAT);
   // R01 inhibited time codes block the start bit; a repeat mode reload does not check them
   assign ack_ok = (ack_cur != 3'b001) && (ack_cur != 3'b111);
   // R14 mode off or reserved stops at once
   assign abort = standby_req || (wr_ctrl1 && !wr_run_mode);
   // R24 latch the datapath when the length has elapsed
   assign store = (state_reg == SADC_CONV) && tif.expire && !abort;
   assign sw_start = (state_reg == SADC_IDLE) && conv_start_bit_reg && !standby_req;

   assign bif.hit = (bif.idx == `SADC_IDX_CTRL1) || (bif.idx == `SADC_IDX_CTRL2) ||
                    (bif.idx == `SADC_IDX_STAT) || (bif.idx == `SADC_IDX_RESH);

   // R02 R03 R08 read data layout
   always_comb begin
      bif.rdata = 8'h00;
      if (bif.idx == `SADC_IDX_CTRL1) begin
         bif.rdata = {conv_start_bit_reg, ctrl1_reg[6:0]};
      end else if (bif.idx == `SADC_IDX_CTRL2) begin
         bif.rdata = {2'b00, ctrl2_reg};
      end else if (bif.idx == `SADC_IDX_STAT) begin
         bif.rdata = {result_reg[1:0], conv_done_flag_reg, conv_busy_flag_reg, 4'h0};
      end else if (bif.idx == `SADC_IDX_RESH) begin
         bif.rdata = result_reg[9:2];
      end
   end

   // R01 conversion length per time code
   always_comb begin
      unique case (ack_cur)
         3'b000: len_next = `SADC_CYC_ACK0;
         3'b010: len_next = `SADC_CYC_ACK2;
         3'b011: len_next = `SADC_CYC_ACK3;
         3'b100: len_next = `SADC_CYC_ACK4;
         3'b101: len_next = `SADC_CYC_ACK5;
         3'b110: len_next = `SADC_CYC_ACK6;
         default: len_next = `SADC_CYC_ACK6;
      endcase
   end

   // sequencer: repeat mode reloads straight after each store
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         SADC_IDLE: begin
            if (sw_start && !abort) begin
               state_next = SADC_LOAD;
            end
         end
         SADC_LOAD: begin
            state_next = abort ? SADC_IDLE : SADC_CONV;
         end
         SADC_CONV: begin
            if (abort) begin
               state_next = SADC_IDLE;
            end else if (tif.expire) begin
               // R13 automatic restart in repeat mode
               state_next = (mode_cur == SADC_MODE_REPEAT) ? SADC_LOAD : SADC_IDLE;
            end
         end
         default: state_next = SADC_IDLE;
      endcase
   end

   assign tif.load = (state_reg == SADC_LOAD) && !abort;
   assign tif.clear = abort;
   assign tif.len = len_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= SADC_IDLE;
         len_reg <= `SADC_CYC_ACK6;
      end else if (pclken) begin
         state_reg <= state_next;
         if (state_next == SADC_LOAD) begin
            len_reg <= len_next;
         end
      end
   end

   // R17 R18 control registers return to reset values in standby
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl1_reg <= `SADC_CTRL1_RST;
         ctrl2_reg <= 6'(`SADC_CTRL2_RST);
      end else if (pclken) begin
         if (standby_req) begin
            ctrl1_reg <= `SADC_CTRL1_RST;
            ctrl2_reg <= 6'(`SADC_CTRL2_RST);
         end else begin
            if (wr_ctrl1) begin
               ctrl1_reg <= {1'b0, bif.wdata[6:0]};
            end
            if (wr_ctrl2) begin
               ctrl2_reg <= bif.wdata[5:0];
            end
         end
      end
   end

   // start bit: R25 ignored when mode off, R11 self clearing on start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_start_bit_reg <= 1'b0;
      end else if (pclken) begin
         if (abort || sw_start) begin
            conv_start_bit_reg <= 1'b0;
         end else if (wr_ctrl1 && bif.wdata[`SADC_START_BIT] && wr_run_mode && ack_ok &&
                      (state_reg == SADC_IDLE)) begin
            // R09 R13 accepted start
            conv_start_bit_reg <= 1'b1;
         end
      end
   end

   // R05 busy flag follows the sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_busy_flag_reg <= 1'b0;
      end else if (pclken) begin
         conv_busy_flag_reg <= (state_next != SADC_IDLE);
      end
   end

   // R04 R06 R15 done flag, a store wins over a clearing read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_done_flag_reg <= 1'b0;
      end else if (pclken) begin
         if (standby_req) begin
            conv_done_flag_reg <= 1'b0;
         end else if (store) begin
            conv_done_flag_reg <= 1'b1;
         end else if (rd_resh || sw_start) begin
            conv_done_flag_reg <= 1'b0;
         end
      end
   end

   // R10 result, done and interrupt in the same step; R17 results lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_reg <= `SADC_RES_RST;
         irq_reg <= 1'b0;
      end else if (pclken) begin
         irq_reg <= store;
         if (standby_req) begin
            result_reg <= `SADC_RES_RST;
         end else if (store) begin
            result_reg <= sar_value;
         end
      end
   end

   // R19 R23 ladder connection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ladder_reg <= 1'b0;
         sar_start_reg <= 1'b0;
      end else if (pclken) begin
         ladder_reg <= !standby_req &&
                       (ctrl2_reg[`SADC_LADDER_BIT] || (state_next != SADC_IDLE));
         sar_start_reg <= tif.load;
      end
   end

   // R22 channel field drives input selector
   assign channel_select_field = ctrl1_reg[`SADC_CHAN_MSB:`SADC_CHAN_LSB];
   assign analog_input_gate = ctrl1_reg[`SADC_GATE_BIT];
   assign ladder_connect_bit = ladder_reg;
   assign conv_done_irq = irq_reg;
   assign sar_start = sar_start_reg;

   // helper count of enabled cycles since the conversion was loaded
   logic [10:0] age_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         age_cnt <= 11'h000;
      end else if (pclken) begin
         age_cnt <= (state_reg == SADC_LOAD) ? 11'h001 : age_cnt + 11'h001;
      end
   end

   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence load_s;
      pclken && (state_reg == SADC_LOAD) && !abort;
   endsequence
   sequence store_s;
      pclken && store;
   endsequence

   conv_length_a: assert property (store_s |-> age_cnt == len_reg) // R01
      else $error("conversion ended at wrong length");
   start_clear_a: assert property (load_s |=> !conv_start_bit_reg) // R11
      else $error("start bit not cleared after start");
   busy_run_a: assert property (state_reg != SADC_IDLE |-> conv_busy_flag_reg) // R05
      else $error("busy low while converting");
   store_flags_a: assert property (store_s |=>
      conv_done_flag_reg && conv_done_irq && result_reg == $past(sar_value)) // R10
      else $error("store did not set result done and irq together");
   read_clear_a: assert property (pclken && rd_resh && !store |=> !conv_done_flag_reg) // R06
      else $error("upper result read did not clear done");
   abort_keep_a: assert property (pclken && !standby_req && abort && state_reg == SADC_CONV
      |=> state_reg == SADC_IDLE && $stable(result_reg)) // R14
      else $error("abort stored a partial result");
   standby_reset_a: assert property (pclken && standby_req |=>
      ctrl1_reg == `SADC_CTRL1_RST && !conv_busy_flag_reg && !ladder_connect_bit) // R17
      else $error("standby did not reset the converter");
   repeat_next_a: assert property (store_s ##0 (mode_cur == SADC_MODE_REPEAT)
      |=> state_reg == SADC_LOAD) // R13
      else $error("repeat mode did not restart");
   off_ignore_a: assert property (pclken && wr_ctrl1 && !wr_run_mode && state_reg == SADC_IDLE
      |=> !conv_start_bit_reg && state_reg == SADC_IDLE && $stable(conv_done_flag_reg)) // R25
      else $error("start accepted with mode off");
   restart_done_a: assert property (pclken && sw_start && !abort |=>
      !conv_done_flag_reg && $stable(result_reg)) // R15
      else $error("restart did not clear done or lost result");
endmodule

// *** tb/sadc_sar_model.sv ***
// sample-hold and comparator stand-in for the converter datapath
`timescale 1ns/10ps
module sadc_sar_model (
   input wire logic pclk,
   input wire logic sar_start,
   input wire logic [9:0] level,
   output logic [9:0] sar_value
);
   logic [9:0] held_reg = 10'h000;
   // input is sampled at each start and held until the next one
   always_ff @(posedge pclk) begin
      if (sar_start === 1'b1) begin
         held_reg <= level;
      end
   end
   assign sar_value = held_reg;
endmodule

// *** tb/test_sar_adc_sequencer.sv ***
// self-checking bench for the converter sequencer over apb
`timescale 1ns/10ps
`include "sadc_consts.svh"
`define CHK(a, b, m) begin n_compared++; \
   if ((a) !== (b)) begin failures++; $display("BAD %0t %s", $time, m); end end
module test_sar_adc_sequencer;
   localparam logic [7:0] C1 = `SADC_IDX_CTRL1;
   localparam logic [7:0] C2 = `SADC_IDX_CTRL2;
   localparam logic [7:0] ST = `SADC_IDX_STAT;
   localparam logic [7:0] RH = `SADC_IDX_RESH;
   logic pclk, presetn, psel, penable, pwrite, standby_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, sar_start, gate, ladder, irq;
   logic [9:0] level, sar_value;
   logic [3:0] chan;
   logic [31:0] rs = 32'd85274;
   int failures = 0, n_compared = 0;
   int cyc = 0, irq_cyc = 0, n_irq = 0, n_start = 0, done_cyc = 0;

   sadc_top i_sadc_top (.pclk(pclk), .presetn(presetn), .pclken(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .standby_req(standby_req), .sar_value(sar_value),
      .sar_start(sar_start), .channel_select_field(chan), .analog_input_gate(gate),
      .ladder_connect_bit(ladder), .conv_done_irq(irq));
   sadc_sar_model i_sadc_sar_model (.pclk(pclk), .sar_start(sar_start), .level(level),
      .sar_value(sar_value));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (irq === 1'b1) begin
         irq_cyc <= cyc;
         n_irq <= n_irq + 1;
      end
      if (sar_start === 1'b1) begin
         n_start <= n_start + 1;
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   function automatic int clen(input logic [2:0] c);
      case (c)
         3'b000: return 39;
         3'b010: return 78;
         3'b011: return 156;
         3'b100: return 312;
         3'b101: return 624;
         default: return 1248;
      endcase
   endfunction

   task automatic tally_and_finish();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
      output logic [7:0] rd, output logic err);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         failures++;
         $display("BAD %0t apb timeout", $time);
         tally_and_finish();
      end
      rd = prdata[7:0];
      err = pslverr;
      done_cyc = cyc;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next call never drives psel twice in one step
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] x, input logic [7:0] m,
      input string s);
      logic [7:0] r;
      logic e;
      apb(1'b0, idx, 8'h00, r, e);
      `CHK(r & m, x & m, s);
      `CHK(e, 1'b0, s);
   endtask

   task automatic wait_irq(input int n);
      int k;
      k = 0;
      // no other port traffic while converting
      while (n_irq < n && k < 2000) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 2000) begin
         failures++;
         $display("BAD %0t irq timeout", $time);
         tally_and_finish();
      end
   endtask

   initial begin
      logic [2:0] codes [6];
      logic [7:0] rc2 [4];
      logic [7:0] rc1 [4];
      logic [7:0] r;
      logic e;
      logic [3:0] ch;
      logic [9:0] lv, lv2;
      int n0, t;
      codes = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
      rc2 = '{8'h02, 8'h0E, 8'h04, 8'h04};
      rc1 = '{8'hA0, 8'hA0, 8'h80, 8'hC0};
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      standby_req = 1'b0;
      level = 10'h000;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(C1, 8'h10, 8'hFF, "ctrl1 reset");
      rdc(C2, 8'h00, 8'hFF, "ctrl2 reset");
      rdc(ST, 8'h00, 8'hF0, "status reset");
      rdc(RH, 8'h00, 8'hFF, "result reset");
      apb(1'b0, 8'h30, 8'h00, r, e);
      `CHK(e, 1'b1, "unmapped read");
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         rs = xs(rs);
         ch = 4'(rs % 6);
         lv = rs[25:16];
         level <= lv;
         // control registers set up before the start bit
         wr(C2, {2'b00, 1'(i % 2), 1'b0, codes[i], 1'b0});
         wr(C1, {3'b001, 1'b0, ch});
         `CHK(ladder, 1'(i % 2), "ladder idle");
         n0 = n_irq;
         wr(C1, {3'b101, 1'b0, ch});
         t = done_cyc;
         rdc(ST, 8'h10, 8'h30, "busy during");
         `CHK(ladder, 1'b1, "ladder converting");
         `CHK(chan, ch, "channel out");
         rdc(C1, {3'b001, 1'b0, ch}, 8'hFF, "start clear");
         wait_irq(n0 + 1);
         `CHK(irq_cyc - t, clen(codes[i]) + 3, "conv length");
         // low bits and status read before the upper result
         rdc(ST, {lv[1:0], 6'h20}, 8'hF0, "status done");
         rdc(RH, lv[9:2], 8'hFF, "result high");
         rdc(ST, 8'h00, 8'h20, "done cleared");
      end
      $display("test single done");
      for (int i = 0; i < 4; i++) begin
         n0 = n_start;
         wr(C2, rc2[i]);
         wr(C1, rc1[i]);
         repeat (20) @(posedge pclk);
         `CHK(n_start, n0, "start refused");
         rdc(ST, 8'h00, 8'h30, "flags unchanged");
      end
      $display("test refused done");
      rs = xs(rs);
      lv = rs[9:0];
      lv2 = rs[29:20];
      level <= lv;
      wr(C2, 8'h00);
      n0 = n_irq;
      wr(C1, 8'hE3);
      repeat (10) @(posedge pclk);
      // first sample already taken; the second conversion samples this level
      level <= lv2;
      wait_irq(n0 + 1);
      t = irq_cyc;
      wait_irq(n0 + 2);
      `CHK(irq_cyc - t, 40, "repeat spacing");
      rdc(ST, {lv2[1:0], 6'h10}, 8'hD0, "repeat status");
      rdc(RH, lv2[9:2], 8'hFF, "repeat result");
      level <= ~lv2;
      wr(C1, 8'h03);
      n0 = n_irq;
      repeat (60) @(posedge pclk);
      `CHK(n_irq, n0, "abort no irq");
      rdc(ST, {lv2[1:0], 6'h00}, 8'hF0, "abort status");
      rdc(RH, lv2[9:2], 8'hFF, "abort result");
      $display("test repeat done");
      n0 = n_irq;
      wr(C1, 8'hA1);
      wait_irq(n0 + 1);
      level <= lv;
      // restart only after completion was seen
      wr(C1, 8'hA1);
      rdc(ST, {~lv2[1:0], 6'h10}, 8'hF0, "restart keeps");
      rdc(RH, ~lv2[9:2], 8'hFF, "old result kept");
      wait_irq(n0 + 2);
      rdc(RH, lv[9:2], 8'hFF, "new result");
      $display("test reconvert done");
      wr(C2, 8'h2C);
      wr(C1, 8'hA2);
      repeat (50) @(posedge pclk);
      n0 = n_irq;
      standby_req <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK(ladder, 1'b0, "ladder off");
      `CHK(gate, 1'b1, "gate reset");
      wr(C1, 8'hA2);
      rdc(C1, 8'h10, 8'hFF, "ctrl1 standby");
      rdc(C2, 8'h00, 8'hFF, "ctrl2 standby");
      rdc(ST, 8'h00, 8'hF0, "status standby");
      standby_req <= 1'b0;
      t = n_start;
      repeat (100) @(posedge pclk);
      `CHK(n_start, t, "idle after");
      `CHK(n_irq, n0, "no irq after");
      $display("test standby done");
      tally_and_finish();
   end
endmodule
